/* File: src/ppr_pkg.sv */
/*
  Constants for the parallel port event reporter: register indices, field positions,
  reset values and timing. Assumes a single device clock domain.
*/
package ppr_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          DISC_TIME_MS  = 1000;
  localparam int          DISC_CYCLES   = (CLK_HZ / 1000) * DISC_TIME_MS;
  localparam logic [3:0]  REG_EXT_CTRL  = 4'h6;
  localparam logic [3:0]  REG_DEV_CTRL  = 4'h7;
  localparam logic [3:0]  REG_SETUP     = 4'h8;
  localparam int          NUM_LINES     = 6;
  // Line order in the peripheral line vector
  localparam int          LN_ACK        = 0;
  localparam int          LN_BUSY       = 1;
  localparam int          LN_FAULT      = 2;
  localparam int          LN_PERR       = 3;
  localparam int          LN_SEL        = 4;
  localparam int          LN_PLH        = 5;
  // Extended control field positions
  localparam int          EC_ACK_INT    = 4;
  localparam int          EC_FAULT_INT  = 3;
  localparam int          EC_BIN_INT    = 2;
  localparam int          EC_BIN_EMPTY  = 1;
  localparam int          EC_BOUT_EMPTY = 0;
  // Device control field positions
  localparam int          DC_DISC_MASK  = 7;
  localparam int          DC_CHG_MASK   = 6;
  localparam int          DC_BIN_MASK   = 5;
  localparam int          DC_BOUT_MASK  = 4;
  localparam int          DC_FAULT_MASK = 3;
  localparam logic [7:0]  DEV_CTRL_RST  = 8'hFB;
  localparam logic [1:0]  SETUP_RST     = 2'h1;
  localparam int          SU_FILT_EN    = 0;
  localparam int          SU_OVERRIDE   = 1;
  localparam logic [2:0]  MODE_ECP      = 3'h3;
  localparam int          NUM_EVENTS    = 7;
  // Event vector order
  localparam int          EV_ACK        = 0;
  localparam int          EV_EPP_TO     = 1;
  localparam int          EV_FAULT      = 2;
  localparam int          EV_BIN        = 3;
  localparam int          EV_BOUT       = 4;
  localparam int          EV_CHG        = 5;
  localparam int          EV_DISC       = 6;
endpackage

/* File: src/parallel_port_event_reporter.sv */
/*
  Event reporter: seven maskable parallel port and data path events, pending status
  cleared by any register read, and input filter selection from bypass_strap, or from the setup register when its override bit is set.
  Assumes a register port with one-cycle read and write strobes, inputs synchronous
  to sys_clk apart from the peripheral lines, which are synchronised here.
*/
module parallel_port_event_reporter
  import ppr_pkg::*;
#(
  parameter int DISC_COUNT = DISC_CYCLES
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  // Register port
  input  wire logic [3:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  // Peripheral lines, raw
  input  wire logic [ppr_pkg::NUM_LINES-1:0]  periph_lines,
  input  wire logic                          bypass_strap,
  // Port state from the mode logic
  input  wire logic [2:0]                    port_mode,
  input  wire logic                          ctrl_int_enable,
  input  wire logic                          epp_to_mask,
  input  wire logic                          epp_timeout,
  // Data path status
  input  wire logic                          bulk_in_avail,
  input  wire logic                          bulk_out_empty,
  // Outputs
  output logic                               filter_on,
  output logic      [ppr_pkg::NUM_EVENTS-1:0] int_pending,
  output logic                               int_req
);
  import ppr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_LINES-1:0]  sync1;
    logic [NUM_LINES-1:0]  sync2;
    logic [NUM_LINES-1:0]  prev;
    logic                  primed;
    logic [4:0]            masks;
    logic [1:0]            setup;
    logic                  ack_st;
    logic                  fault_st;
    logic                  bin_st;
    logic                  bout_prev;
    logic                  fmask_prev;
    logic [31:0]           disc_cnt;
    logic                  disc_fired;
    logic [NUM_EVENTS-1:0] pend;
    logic [7:0]            rdata;
    logic                  filt;
    logic                  req;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [NUM_LINES-1:0]  rise;
  logic [NUM_LINES-1:0]  fall;
  logic [NUM_EVENTS-1:0] ev;
  logic                  fault_mask;
  logic                  disc_cond;
  logic                  disc_timeout;
  logic [NUM_EVENTS-1:0] ev_raw;
  logic [NUM_EVENTS-1:0] ev_allow;
  logic                  wr_dev;
  logic                  wr_setup;
  logic [7:0]            ext_view;
  logic [7:0]            dev_view;
  logic [7:0]            setup_view;

  // Mask field k sits at bit k + MASK_BASE of the device control register
  localparam int MASK_BASE = DC_FAULT_MASK;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = periph_lines;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    st_nxt.primed = 1'b1;
    // No edges in the first cycle out of reset, before primed is set
    rise = st_r.primed ? (st_r.sync2 & ~st_r.prev) : '0;
    fall = st_r.primed ? (~st_r.sync2 & st_r.prev) : '0;
    fault_mask = st_r.masks[DC_FAULT_MASK-MASK_BASE];

    // Disconnect long-high detector
    disc_cond = ~st_r.sync2[LN_PLH] & st_r.sync2[LN_ACK] & st_r.sync2[LN_BUSY] &
                st_r.sync2[LN_FAULT] & st_r.sync2[LN_PERR] & st_r.sync2[LN_SEL];
    disc_timeout = 1'b0;
    if (!disc_cond) begin
      st_nxt.disc_cnt   = '0;
      st_nxt.disc_fired = 1'b0;
    end else if (!st_r.disc_fired) begin
      if (st_r.disc_cnt >= 32'(DISC_COUNT)) begin
        disc_timeout      = 1'b1;
        st_nxt.disc_fired = 1'b1;
      end else begin
        st_nxt.disc_cnt = st_r.disc_cnt + 32'h1;
      end
    end

    // Raw conditions and enables kept apart, so each mask stands on its own
    ev_raw              = '0;
    ev_raw[EV_ACK]      = rise[LN_ACK];
    ev_raw[EV_EPP_TO]   = epp_timeout;
    ev_raw[EV_FAULT]    = (port_mode == MODE_ECP) &
                          (fall[LN_FAULT] | (st_r.fmask_prev & ~st_r.sync2[LN_FAULT]));
    ev_raw[EV_BIN]      = bulk_in_avail;
    ev_raw[EV_BOUT]     = bulk_out_empty & ~st_r.bout_prev;
    ev_raw[EV_CHG]      = |(rise | fall);
    ev_raw[EV_DISC]     = fall[LN_PLH] | disc_timeout;

    // Only the ack event follows the control enable; time-out has its own mask
    ev_allow            = '0;
    ev_allow[EV_ACK]    = ctrl_int_enable;
    ev_allow[EV_EPP_TO] = ~epp_to_mask;
    ev_allow[EV_FAULT]  = ~fault_mask;
    ev_allow[EV_BIN]    = ~st_r.masks[DC_BIN_MASK-MASK_BASE];
    ev_allow[EV_BOUT]   = ~st_r.masks[DC_BOUT_MASK-MASK_BASE];
    ev_allow[EV_CHG]    = ~st_r.masks[DC_CHG_MASK-MASK_BASE];
    ev_allow[EV_DISC]   = ~st_r.masks[DC_DISC_MASK-MASK_BASE];

    ev = ev_raw & ev_allow;
    st_nxt.bout_prev  = bulk_out_empty;
    st_nxt.fmask_prev = fault_mask;

    // Read clears pending; a same-cycle event still lands
    if (reg_rd) begin
      st_nxt.pend     = ev;
      st_nxt.ack_st   = ev[EV_ACK];
      st_nxt.fault_st = ev[EV_FAULT];
      st_nxt.bin_st   = ev[EV_BIN];
    end else begin
      st_nxt.pend     = st_r.pend | ev;
      st_nxt.ack_st   = st_r.ack_st | ev[EV_ACK];
      st_nxt.fault_st = st_r.fault_st | ev[EV_FAULT];
      st_nxt.bin_st   = st_r.bin_st | ev[EV_BIN];
    end
    st_nxt.req = |st_nxt.pend;

    // Register views, used by the read mux
    ext_view   = {port_mode, st_r.ack_st, st_r.fault_st, st_r.bin_st,
                  ~bulk_in_avail, bulk_out_empty};
    dev_view   = {st_r.masks, 3'h0};
    setup_view = {6'h00, st_r.setup};
    wr_dev     = reg_wr & (reg_addr == REG_DEV_CTRL);
    wr_setup   = reg_wr & (reg_addr == REG_SETUP);

    if (wr_dev) begin
      st_nxt.masks = reg_wdata[DC_DISC_MASK:DC_FAULT_MASK];
    end
    if (wr_setup) begin
      st_nxt.setup = reg_wdata[SU_OVERRIDE:SU_FILT_EN];
    end

    // Read data holds between reads
    st_nxt.rdata = st_r.rdata;
    if (reg_rd) begin
      case (reg_addr)
        REG_EXT_CTRL: begin
          st_nxt.rdata = ext_view;
        end
        REG_DEV_CTRL: begin
          st_nxt.rdata = dev_view;
        end
        REG_SETUP: begin
          st_nxt.rdata = setup_view;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    st_nxt.filt = st_r.setup[SU_OVERRIDE] ? st_r.setup[SU_FILT_EN]
                                          : bypass_strap;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // History starts at the idle-high level, so release brings no false edge
      st_r.sync1      <= '1;
      st_r.sync2      <= '1;
      st_r.prev       <= '1;
      st_r.primed     <= 1'b0;
      st_r.masks      <= DEV_CTRL_RST[DC_DISC_MASK:DC_FAULT_MASK];
      st_r.setup      <= SETUP_RST;
      st_r.ack_st     <= 1'b0;
      st_r.fault_st   <= 1'b0;
      st_r.bin_st     <= 1'b0;
      st_r.bout_prev  <= 1'b0;
      st_r.fmask_prev <= 1'b0;
      st_r.disc_cnt   <= '0;
      st_r.disc_fired <= 1'b0;
      st_r.pend       <= '0;
      st_r.rdata      <= 8'h00;
      st_r.filt       <= 1'b1;
      st_r.req        <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata   = st_r.rdata;
  assign filter_on   = st_r.filt;
  assign int_pending = st_r.pend;
  assign int_req     = st_r.req;
endmodule

/* File: verif/ppr_periph.sv */
/* Peripheral model: drives its six status lines. Assumes one clock, lines idle high. */
module ppr_periph (
  input  wire logic       sys_clk,
  input  wire logic [5:0] want_lines,
  output logic      [5:0] periph_lines
);
  // Moves just after an edge, unaligned to any request
  always @(posedge sys_clk) periph_lines <= want_lines;
endmodule

/* File: verif/ppr_sva.sv */
/* Port checker for the event reporter. Assumes binding to its top module. */
module ppr_checker
  import ppr_pkg::*;
#(parameter int DISC_COUNT = 20) (
  input wire logic sys_clk, resetn, reg_rd, ctrl_int_enable, epp_to_mask, epp_timeout,
  input wire logic bulk_in_avail, bulk_out_empty, int_req,
  input wire logic [3:0] reg_addr,
  input wire logic [2:0] port_mode,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_EVENTS-1:0] int_pending
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_ext_rd; reg_rd && reg_addr == REG_EXT_CTRL; endsequence
  sequence s_quiet_rd; reg_rd && !bulk_in_avail && !epp_timeout; endsequence
  AST_REQ: assert property (int_req == |int_pending)
    else $error("request differs from pending");
  AST_CLR: assert property (s_quiet_rd |=> !int_pending[EV_BIN] && !int_pending[EV_EPP_TO])
    else $error("pending survived a read");
  AST_EXT: assert property (s_ext_rd |=> reg_rdata[7:5] == $past(port_mode) &&
    reg_rdata[1:0] == {!$past(bulk_in_avail), $past(bulk_out_empty)})
    else $error("ext ctrl flags wrong");
  AST_ACK: assert property ($rose(int_pending[EV_ACK]) |-> $past(ctrl_int_enable))
    else $error("ack event while disabled");
  AST_EPP: assert property ($rose(int_pending[EV_EPP_TO]) |-> $past(epp_timeout) && !$past(epp_to_mask))
    else $error("time-out event unexpected");
  AST_FLT: assert property ($rose(int_pending[EV_FAULT]) |-> $past(port_mode) == MODE_ECP)
    else $error("fault event outside ECP");
  AST_BIN: assert property ($rose(int_pending[EV_BIN]) |-> $past(bulk_in_avail))
    else $error("bulk-in event without data");
  AST_BOUT: assert property ($rose(int_pending[EV_BOUT]) |-> $past(bulk_out_empty) && !$past(bulk_out_empty, 2))
    else $error("bulk-out event without empty edge");
endmodule
////////////////////////////////////////////////////////////////////////
bind parallel_port_event_reporter ppr_checker #(.DISC_COUNT(DISC_COUNT)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .reg_rd(reg_rd), .ctrl_int_enable(ctrl_int_enable), .epp_to_mask(epp_to_mask), .epp_timeout(epp_timeout),
  .bulk_in_avail(bulk_in_avail), .bulk_out_empty(bulk_out_empty), .int_req(int_req), .reg_addr(reg_addr),
  .port_mode(port_mode), .reg_rdata(reg_rdata), .int_pending(int_pending));

/* File: verif/tb_parallel_port_event_reporter.sv */
/* Bench for the event reporter. Assumes the package, the peripheral model and the checker. */
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_parallel_port_event_reporter;
  timeunit 1ns;
  timeprecision 1ns;
  import ppr_pkg::*;
  logic sys_clk, resetn, reg_wr, reg_rd, bypass_strap, ctrl_int_enable, epp_to_mask, epp_timeout;
  logic bulk_in_avail, bulk_out_empty, filter_on, int_req, rd_seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rnd, got_exp;
  logic [2:0] port_mode;
  logic [5:0] want_lines, periph_lines;
  logic [6:0] int_pending;
  logic [7:0] exp_q[$];
  int fails, tests_run;
  parallel_port_event_reporter #(.DISC_COUNT(20)) DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .periph_lines(periph_lines),
    .bypass_strap(bypass_strap), .port_mode(port_mode), .ctrl_int_enable(ctrl_int_enable), .epp_to_mask(epp_to_mask),
    .epp_timeout(epp_timeout), .bulk_in_avail(bulk_in_avail), .bulk_out_empty(bulk_out_empty),
    .filter_on(filter_on), .int_pending(int_pending), .int_req(int_req));
  ppr_periph peer (.sys_clk(sys_clk), .want_lines(want_lines), .periph_lines(periph_lines));
  ////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
  endtask
  // Lines pass the model and a two-stage sync, so allow seven cycles
  task automatic ev(input logic [6:0] e);
    repeat (7) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("pending", e, int_pending)
    `CHK("request", |e, int_req)
    acc(0, REG_EXT_CTRL, {port_mode, e[EV_ACK], e[EV_FAULT], e[EV_BIN], !bulk_in_avail, bulk_out_empty});
    @(negedge sys_clk);
    `CHK("cleared", 7'(bulk_in_avail) << EV_BIN, int_pending)
    @(posedge sys_clk);
  endtask
  task automatic filt(input logic [7:0] d, input logic e);
    acc(1, REG_SETUP, d);
    repeat (2) @(negedge sys_clk);
    `CHK("filter", e, filter_on)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      got_exp = exp_q.pop_front();
      `CHK("rdata", got_exp, reg_rdata)
    end
    rd_seen <= reg_rd;
  end
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    final_report;
  end
  initial begin
    void'($urandom(32'h67C2));
    rnd = 8'($urandom);
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, epp_timeout, bulk_in_avail, bulk_out_empty, port_mode} = '0;
    {ctrl_int_enable, epp_to_mask, bypass_strap, want_lines} = {2'b11, rnd[7], 6'h3F};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    acc(0, REG_DEV_CTRL, 8'hF8);
    acc(0, 4'h3, 8'h00);
    want_lines[LN_ACK] <= 1'b0;
    ev(7'h00);
    acc(1, REG_DEV_CTRL, 8'h00);
    want_lines[LN_ACK] <= 1'b1;
    ev(7'h21);
    port_mode <= MODE_ECP;
    want_lines[LN_FAULT] <= 1'b0;
    ev(7'h24);
    acc(1, REG_DEV_CTRL, 8'h08);
    acc(1, REG_DEV_CTRL, 8'h00);
    ev(7'h04);
    want_lines[LN_FAULT] <= 1'b1;
    ev(7'h20);
    {epp_to_mask, epp_timeout} <= 2'b01;
    @(posedge sys_clk) epp_timeout <= 1'b0;
    ev(7'h02);
    {epp_to_mask, epp_timeout} <= 2'b11;
    @(posedge sys_clk) epp_timeout <= 1'b0;
    ev(7'h00);
    bulk_out_empty <= 1'b1;
    ev(7'h10);
    bulk_in_avail <= 1'b1;
    ev(7'h08);
    bulk_in_avail <= 1'b0;
    ev(7'h08);
    want_lines[LN_BUSY] <= 1'b0;
    ev(7'h20);
    want_lines[LN_PLH] <= 1'b0;
    ev(7'h60);
    want_lines[LN_BUSY] <= 1'b1;
    ev(7'h20);
    repeat (14) @(posedge sys_clk);
    ev(7'h40);
    filt({rnd[5:0], 2'b10}, 1'b0);
    acc(0, REG_SETUP, 8'h02);
    filt(8'h03, 1'b1);
    filt(8'h00, bypass_strap);
    final_report;
  end
endmodule
